// >>> capture_compare_timer_counter.sv
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_counter
  import timer_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [1:0]            startBits,
  input  wire chanCfg_type [1:0]     chanCfg,
  input  wire logic [1:0][3:0]       grLoad,
  input  wire logic [15:0]           grData,
  input  wire logic [1:0][4:0]       flagClear,
  input  wire logic                  osc40Tick,
  input  wire logic                  extClockPin,
  input  wire logic [1:0][3:0]       capcmpIn,
  input  wire pinDCfg_type           pinDCfg,
  input  wire logic                  complPwmWave,
  input  wire logic                  resetSyncPwmWave,
  input  wire logic                  pwmWave,
  input  wire logic                  gpioOut,
  input  wire logic                  gpioOe,
  output var  chanState_type [1:0]   chanStatus,
  output var  pinDFunc_type          chan1PinDFunc,
  output var  logic                  chan1PinDOut,
  output var  logic                  chan1PinDOe
);

  // ==========================================================
  // Decode helpers
  function automatic logic edgeHit(input logic [1:0] sel, input logic now,
                                   input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    if (sel == EDGE_RISE) begin
      edgeHit = rise;
    end else if (sel == EDGE_FALL) begin
      edgeHit = fall;
    end else begin
      edgeHit = rise | fall;
    end
  endfunction

  function automatic logic countTick(input chanCfg_type cfg, input logic [4:0] div,
                                     input logic osc, input logic ext,
                                     input logic extPrev);
    case (cfg.prescalerSelect)
      PSC_DIV1:  countTick = 1'b1;
      PSC_DIV2:  countTick = div[0];
      PSC_DIV4:  countTick = &div[1:0];
      PSC_DIV8:  countTick = &div[2:0];
      PSC_DIV32: countTick = &div;
      PSC_OSC:   countTick = osc;
      default:   countTick = edgeHit(cfg.extEdgeSelect, ext, extPrev);
    endcase
  endfunction

  function automatic pinDFunc_type pinDFunction(input pinDCfg_type p,
                                                input logic [2:0] io);
    if (p.outputDisable) begin
      pinDFunction = FN_GPIO;
    end else if (p.combinationMode[1]) begin
      pinDFunction = FN_COMPL;
    end else if (p.combinationMode == CMD_RSYNC) begin
      pinDFunction = FN_RSYNC;
    end else if (!p.pwmVariant) begin
      pinDFunction = FN_GPIO;
    end else if (p.pwmSelect) begin
      pinDFunction = FN_PWM;
    end else if (io[IO_CAP]) begin
      pinDFunction = FN_CAPTURE;
    end else if (io != IO_NONE) begin
      pinDFunction = FN_COMPARE;
    end else begin
      pinDFunction = FN_GPIO;
    end
  endfunction

  // ==========================================================
  // State
  state_type             stateReg;
  state_type             stateNext;
  logic [1:0]            tickVec;
  logic [1:0][3:0]       matchVec;

  always_comb begin
    chanState_type cs;
    chanState_type ns;
    pinDFunc_type  fn;
    logic          tick;
    logic          isCap;
    logic          isCmp;
    logic          capHit;
    logic          clr;
    logic [3:0]    ev;
    cs = '0;
    ns = '0;
    fn = FN_GPIO;
    tick = 1'b0;
    isCap = 1'b0;
    isCmp = 1'b0;
    capHit = 1'b0;
    clr = 1'b0;
    ev = '0;
    tickVec = '0;
    matchVec = '0;
    stateNext = stateReg;
    stateNext.divCnt = stateReg.divCnt + 5'h01;
    stateNext.extPrev = extClockPin;
    fn = pinDFunction(pinDCfg, chanCfg[1].ioSelect[PIN_D]);
    for (int c = 0; c < 2; c++) begin
      cs = stateReg.ch[c];
      ns = cs;
      ns.pinPrev = capcmpIn[c];
      // Stopped counters hold; capture still records the frozen value
      tick = startBits[c] & countTick(chanCfg[c], stateReg.divCnt, osc40Tick,
                                      extClockPin, stateReg.extPrev);
      tickVec[c] = tick;
      for (int i = 0; i < 4; i++) begin
        isCap = chanCfg[c].ioSelect[i][IO_CAP];
        isCmp = !isCap && chanCfg[c].ioSelect[i] != IO_NONE;
        if (c == 1 && i == PIN_D) begin
          isCap = fn == FN_CAPTURE;
          isCmp = fn == FN_COMPARE;
        end
        // Match fires on the count edge that leaves the equal value
        matchVec[c][i] = tick && !isCap && cs.count == cs.gr[i];
        capHit = isCap && edgeHit(chanCfg[c].ioSelect[i][1:0], capcmpIn[c][i],
                                  cs.pinPrev[i]);
        if (grLoad[c][i]) begin
          ns.gr[i] = grData;
        end
        if (capHit) begin
          ns.gr[i] = cs.count;
        end
        if (isCmp && matchVec[c][i]) begin
          case (chanCfg[c].ioSelect[i])
            IO_LOW:    ns.pinLevel[i] = 1'b0;
            IO_HIGH:   ns.pinLevel[i] = 1'b1;
            default:   ns.pinLevel[i] = ~cs.pinLevel[i];
          endcase
        end
        ns.pinOe[i] = isCmp;
        ev[i] = matchVec[c][i] || capHit;
      end
      clr = startBits[c] && chanCfg[c].clearSource != CLR_NONE &&
            chanCfg[c].clearSource <= CLR_D &&
            ev[2'(chanCfg[c].clearSource - CLR_A)];
      if (clr) begin
        ns.count = COUNT_RESET;
      end else if (tick) begin
        ns.count = cs.count + 16'h0001;
      end
      // Set wins over a clear in the same cycle
      ns.flags = (cs.flags & ~flagClear[c]) |
                 {ev, tick && !clr && cs.count == COUNT_MAX};
      ns.irq = |(ns.flags & chanCfg[c].irqEnable);
      stateNext.ch[c] = ns;
    end
    stateNext.dFunc = fn;
    case (fn)
      FN_COMPL:   stateNext.dOut = complPwmWave;
      FN_RSYNC:   stateNext.dOut = resetSyncPwmWave;
      FN_PWM:     stateNext.dOut = pwmWave;
      FN_COMPARE: stateNext.dOut = stateNext.ch[1].pinLevel[PIN_D];
      FN_CAPTURE: stateNext.dOut = 1'b0;
      default:    stateNext.dOut = gpioOut;
    endcase
    stateNext.dOe = (fn == FN_GPIO) ? gpioOe : (fn != FN_CAPTURE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign chanStatus    = stateReg.ch;
  assign chan1PinDFunc = stateReg.dFunc;
  assign chan1PinDOut  = stateReg.dOut;
  assign chan1PinDOe   = stateReg.dOe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence wrapSeq;
    tickVec[0] && stateReg.ch[0].count == COUNT_MAX &&
    chanCfg[0].clearSource == CLR_NONE;
  endsequence

  stop_hold_a: assert property (!startBits[0] |=> $stable(stateReg.ch[0].count))
    else $error("stopped counter moved");
  ovf_wrap_a: assert property (wrapSeq |=> stateReg.ch[0].flags[FLAG_OVF] &&
      stateReg.ch[0].count == COUNT_RESET)
    else $error("overflow not flagged or no wrap");
  ovf_irq_a: assert property (wrapSeq ##0 chanCfg[0].irqEnable[FLAG_OVF]
      |=> stateReg.ch[0].irq)
    else $error("overflow interrupt missing");
  match_clear_a: assert property (matchVec[0][PIN_A] && startBits[0] &&
      chanCfg[0].clearSource == CLR_A |=> stateReg.ch[0].count == COUNT_RESET &&
      stateReg.ch[0].flags[FLAG_A])
    else $error("periodic clear failed");
  match_irq_a: assert property (matchVec[1][PIN_B] &&
      chanCfg[1].irqEnable[FLAG_A + PIN_B] |=> stateReg.ch[1].irq)
    else $error("match interrupt missing");
  div2_rate_a: assert property (tickVec[0] &&
      chanCfg[0].prescalerSelect == PSC_DIV2 |=> !tickVec[0])
    else $error("divide by two ticks too fast");
  ext_rise_a: assert property (startBits[0] && $rose(extClockPin) &&
      chanCfg[0].prescalerSelect == PSC_EXT && chanCfg[0].extEdgeSelect == EDGE_RISE
      |-> tickVec[0])
    else $error("external rising edge not counted");
  cmp_high_a: assert property (matchVec[0][PIN_A] &&
      chanCfg[0].ioSelect[PIN_A] == IO_HIGH |=> stateReg.ch[0].pinLevel[PIN_A])
    else $error("compare high not driven");
  cmp_keep_a: assert property (matchVec[0][PIN_B] &&
      chanCfg[0].ioSelect[PIN_B] == IO_LOW && !stateReg.ch[0].pinLevel[PIN_B]
      |=> !stateReg.ch[0].pinLevel[PIN_B])
    else $error("equal level changed pin");
  capture_a: assert property (chanCfg[0].ioSelect[PIN_A] == {1'b1, EDGE_RISE} &&
      $rose(stateReg.ch[0].pinPrev[PIN_A]) |-> stateReg.ch[0].gr[PIN_A] ==
      $past(stateReg.ch[0].count))
    else $error("capture value wrong");
  pin_compl_a: assert property (!pinDCfg.outputDisable &&
      pinDCfg.combinationMode[1] |=> chan1PinDFunc == FN_COMPL)
    else $error("pin D not complementary PWM");
  pin_gpio_a: assert property (pinDCfg.outputDisable |=> chan1PinDFunc == FN_GPIO)
    else $error("pin D not port when disabled");

endmodule
`default_nettype wire

// >>> timer_pkg.sv
// Function
// - D1 pin carries complementary PWM wave
// - D1 pin carries reset-synchronous PWM wave
// - D1 pin carries plain PWM wave
// - D1 pin acts as compare output
// - D1 pin acts as capture input
// - Start bit high makes counter count
// - Counters default to free-running after reset
// - Overflow sets flag, counter wraps to zero
// - Enabled overflow flag raises interrupt request
// - Clear source selects compare-match clearing
// - Match sets flag; clears counter when clear source selects it
// - Enabled match flag raises interrupt request
// - Prescaler picks system, divided or oscillator
// - External clock counts rise, fall or both
// - Compare match drives pin low, high, toggle
// - Level equal to pin leaves pin unchanged
// - Match fires as counter leaves matching value
// - Match applies selected level to pin
// - Capture edge copies counter into register
// - Capture edge selectable rise, fall, both
// - Capture event may clear the counter
package timer_pkg;
  localparam int          CNT_W       = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [4:0]  DIV_RESET   = 5'h00;
  // Prescaler codes
  localparam logic [2:0] PSC_DIV1  = 3'h0;
  localparam logic [2:0] PSC_DIV2  = 3'h1;
  localparam logic [2:0] PSC_DIV4  = 3'h2;
  localparam logic [2:0] PSC_DIV8  = 3'h3;
  localparam logic [2:0] PSC_DIV32 = 3'h4;
  localparam logic [2:0] PSC_OSC   = 3'h5;
  localparam logic [2:0] PSC_EXT   = 3'h6;
  // Edge select codes, 2 and 3 both mean both edges
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Pin I/O select; bit 2 set means capture, low bits give the edge
  localparam logic [2:0] IO_NONE   = 3'h0;
  localparam logic [2:0] IO_LOW    = 3'h1;
  localparam logic [2:0] IO_HIGH   = 3'h2;
  localparam logic [2:0] IO_TOGGLE = 3'h3;
  localparam int         IO_CAP    = 2;
  // Clear source codes
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_A    = 3'h1;
  localparam logic [2:0] CLR_B    = 3'h2;
  localparam logic [2:0] CLR_D    = 3'h4;
  // Flag and pin positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_A   = 1;
  localparam int PIN_A    = 0;
  localparam int PIN_B    = 1;
  localparam int PIN_D    = 3;
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_RSYNC  = 2'h1;

  typedef enum logic [2:0] {
    FN_GPIO = 3'h0, FN_COMPARE = 3'h1, FN_CAPTURE = 3'h3,
    FN_PWM = 3'h2, FN_RSYNC = 3'h6, FN_COMPL = 3'h7
  } pinDFunc_type;

  typedef struct packed {
    logic [2:0]      prescalerSelect;
    logic [1:0]      extEdgeSelect;
    logic [2:0]      clearSource;
    logic [3:0][2:0] ioSelect;
    logic [4:0]      irqEnable;
  } chanCfg_type;

  typedef struct packed {
    logic       outputDisable;
    logic [1:0] combinationMode;
    logic       pwmVariant;
    logic       pwmSelect;
  } pinDCfg_type;

  typedef struct packed {
    logic [15:0]       count;
    logic [3:0][15:0]  gr;
    logic [4:0]        flags;
    logic [3:0]        pinLevel;
    logic [3:0]        pinOe;
    logic [3:0]        pinPrev;
    logic              irq;
  } chanState_type;

  typedef struct packed {
    logic [4:0]               divCnt;
    logic                     extPrev;
    chanState_type [1:0]      ch;
    pinDFunc_type             dFunc;
    logic                     dOut;
    logic                     dOe;
  } state_type;
endpackage

// >>> pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Far-side pins
module pin_model (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  output var  logic            osc40Tick,
  output var  logic            extClockPin,
  output var  logic [1:0][3:0] capcmpIn,
  output var  logic [2:0]      waves
);
  logic [2:0] phase;
  // Stand-in oscillator rate, one tick in eight
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  assign osc40Tick = (phase == 3'h7);
  assign waves     = phase;
  initial begin
    capcmpIn    = '0;
    extClockPin = 1'b0;
  end
  task automatic pinSet(input int c, input int i, input logic v);
    @(posedge mclk);
    capcmpIn[c][i] <= v;
  endtask
  // Clock stands low between bursts
  task automatic extPulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      extClockPin <= 1'b1;
      repeat (2) @(posedge mclk);
      extClockPin <= 1'b0;
      @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> test_capture_compare_timer_counter.sv
`timescale 1ns/1ns
`default_nettype none
module test_capture_compare_timer_counter
  import timer_pkg::*;
;
  logic                mclk      = 1'b0;
  logic                rst_n     = 1'b0;
  logic [1:0]          startBits = 2'h0;
  chanCfg_type [1:0]   chanCfg   = '0;
  logic [1:0][3:0]     grLoad    = '0;
  logic [15:0]         grData    = 16'h0000;
  logic [1:0][4:0]     flagClear = '0;
  pinDCfg_type         pinDCfg   = '0;
  logic                gpioOut   = 1'b1;
  logic                gpioOe    = 1'b1;
  logic                osc40Tick;
  logic                extClockPin;
  logic [1:0][3:0]     capcmpIn;
  logic [2:0]          waves;
  logic [2:0]          wavesPrev;
  chanState_type [1:0] st;
  pinDFunc_type        dFunc;
  logic                dOut;
  logic                dOe;
  int                  error_cnt = 0;
  int                  tests_run = 0;
  int                  cycles    = 0;

  always #2 mclk = ~mclk;
  // Pin D drive lags the routed wave by one register stage
  always @(posedge mclk) wavesPrev <= waves;

  pin_model pins (.mclk(mclk), .rst_n(rst_n), .osc40Tick(osc40Tick),
    .extClockPin(extClockPin), .capcmpIn(capcmpIn), .waves(waves));
  capture_compare_timer_counter uut (.mclk(mclk), .rst_n(rst_n), .startBits(startBits),
    .chanCfg(chanCfg), .grLoad(grLoad), .grData(grData), .flagClear(flagClear),
    .osc40Tick(osc40Tick), .extClockPin(extClockPin), .capcmpIn(capcmpIn),
    .pinDCfg(pinDCfg), .complPwmWave(waves[0]), .resetSyncPwmWave(waves[1]),
    .pwmWave(waves[2]), .gpioOut(gpioOut), .gpioOe(gpioOe), .chanStatus(st),
    .chan1PinDFunc(dFunc), .chan1PinDOut(dOut), .chan1PinDOe(dOe));

  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic doReset;
    @(posedge mclk);
    rst_n <= 1'b0;
    startBits <= 2'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  task automatic go;
    @(posedge mclk);
    startBits <= 2'h1;
  endtask
  task automatic stop_test;
    $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic countTest;
    logic [2:0]  psc [9] = '{PSC_DIV1, PSC_DIV2, PSC_DIV4, PSC_DIV8, PSC_DIV32,
                            PSC_OSC, PSC_EXT, PSC_EXT, PSC_EXT};
    logic [1:0]  edg [3] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    logic [15:0] exp [9] = '{16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0002,
                            16'h0008, 16'h0004, 16'h0004, 16'h0008};
    for (int k = 0; k < 9; k++) begin
      @(posedge mclk);
      chanCfg[0].prescalerSelect <= psc[k];
      chanCfg[0].extEdgeSelect <= edg[k % 3];
      doReset();
      cyc(2);
      chk(st[0].count, 16'h0000);
      go();
      if (k < 6) begin
        cyc(64);
        chk(st[0].count, exp[k]);
      end else begin
        pins.extPulses(4);
        cyc(3);
        chk(st[0].count, exp[k]);
      end
    end
    $display("count clock test done");
  endtask

  // Full wrap at the undivided clock, the longest part of the run
  task automatic ovfTest;
    @(posedge mclk);
    chanCfg[0] <= '{irqEnable: 5'h01, default: '0};
    doReset();
    go();
    cyc(65535);
    chk(st[0].count, COUNT_MAX);
    chk(16'(st[0].flags[FLAG_OVF]), 16'h0000);
    cyc(1);
    chk(st[0].count, COUNT_RESET);
    chk(16'(st[0].flags[FLAG_OVF]), 16'h0001);
    chk(16'(st[0].irq), 16'h0001);
    @(posedge mclk);
    flagClear[0][FLAG_OVF] <= 1'b1;
    @(posedge mclk);
    flagClear[0][FLAG_OVF] <= 1'b0;
    cyc(1);
    chk(16'(st[0].irq), 16'h0000);
    $display("overflow test done");
  endtask

  task automatic cmpTest;
    logic [2:0]  io [5]  = '{IO_TOGGLE, IO_LOW, IO_LOW, IO_HIGH, IO_HIGH};
    logic [15:0] lvl [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001};
    @(posedge mclk);
    chanCfg[0] <= '{clearSource: CLR_A, irqEnable: 5'h02, ioSelect: {9'h000, IO_TOGGLE},
                    default: '0};
    chanCfg[1] <= '{irqEnable: 5'h04, default: '0};
    doReset();
    @(posedge mclk);
    grData <= 16'h0005;
    grLoad[0][PIN_A] <= 1'b1;
    @(posedge mclk);
    grLoad[0][PIN_A] <= 1'b0;
    startBits <= 2'h3;
    cyc(5);
    chk(st[0].count, 16'h0005);
    chk(16'(st[0].flags[FLAG_A]), 16'h0000);
    cyc(1);
    chk(st[0].count, COUNT_RESET);
    chk(16'(st[0].flags[FLAG_A]), 16'h0001);
    chk(16'(st[0].irq), 16'h0001);
    chk(16'(st[1].irq), 16'h0001);
    chk(16'(st[0].pinOe[PIN_A]), 16'h0001);
    chk(16'(st[0].pinLevel[PIN_A]), 16'h0001);
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      chanCfg[0].ioSelect[PIN_A] <= io[k];
      cyc(5);
      chk(16'(st[0].pinLevel[PIN_A]), lvl[k]);
    end
    $display("compare test done");
  endtask

  task automatic capTest;
    @(posedge mclk);
    chanCfg[0] <= '{clearSource: CLR_B, default: '0,
                    ioSelect: {6'h00, 1'b1, EDGE_FALL, 1'b1, EDGE_RISE}};
    doReset();
    go();
    pins.pinSet(0, PIN_B, 1'b1);
    pins.pinSet(0, PIN_A, 1'b1);
    #1;
    chk(st[0].gr[PIN_B], 16'h0000);
    pins.pinSet(0, PIN_B, 1'b0);
    cyc(1);
    chk(st[0].gr[PIN_A], 16'h0002);
    chk(st[0].gr[PIN_B], 16'h0003);
    chk(st[0].count, COUNT_RESET);
    $display("capture test done");
  endtask

  task automatic pinDTest;
    logic [4:0]   cfg [11] = '{5'h08, 5'h0c, 5'h04, 5'h03, 5'h02, 5'h02, 5'h02, 5'h02,
                              5'h18, 5'h02, 5'h00};
    logic [2:0]   io [11]  = '{3'h0, 3'h7, 3'h4, 3'h1, 3'h1, 3'h2, 3'h3, 3'h5,
                              3'h1, 3'h0, 3'h1};
    pinDFunc_type fn [11]  = '{FN_COMPL, FN_COMPL, FN_RSYNC, FN_PWM, FN_COMPARE, FN_COMPARE,
                              FN_COMPARE, FN_CAPTURE, FN_GPIO, FN_GPIO, FN_GPIO};
    for (int k = 0; k < 11; k++) begin
      @(posedge mclk);
      pinDCfg <= cfg[k];
      chanCfg[1].ioSelect[PIN_D] <= io[k];
      cyc(2);
      chk(16'(dFunc), 16'(fn[k]));
      if (fn[k] == FN_GPIO) chk(16'({dOe, dOut}), 16'h0003);
      if (fn[k] == FN_COMPARE) chk(16'({dOe, dOut}), 16'h0002);
      if (fn[k] == FN_CAPTURE) chk(16'({dOe, dOut}), 16'h0000);
      if (fn[k] == FN_COMPL) chk(16'(dOut), 16'(wavesPrev[0]));
      if (fn[k] == FN_RSYNC) chk(16'(dOut), 16'(wavesPrev[1]));
      if (fn[k] == FN_PWM) chk(16'(dOut), 16'(wavesPrev[2]));
    end
    $display("pin D test done");
  endtask

  // ==========
  // Sequence and hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    doReset();
    countTest();
    ovfTest();
    cmpTest();
    capTest();
    pinDTest();
    stop_test();
  end
endmodule
`default_nettype wire
